// ### logic/fcdf_top.sv
// Frequency reached, overcurrent and zero-current flag generation
`timescale 1ns/1ps
`default_nettype none
module fcdf_top #(
  parameter int TICK_CYC = fcdf_pkg::TICK_CYC  // Cycles per 1 ms tick; must fit in TICK_W bits
) (
  input  wire logic                          clk,              // 200 MHz clock
  input  wire logic                          resetn,           // Async reset, active low
  input  wire logic [fcdf_pkg::FREQ_W-1:0]   out_freq_raw,     // Frequency before slip comp, 0.01 Hz
  input  wire logic                          reverse_run,      // High during reverse rotation
  input  wire logic                          dc_brake,         // DC injection braking active
  input  wire logic                          running,          // Drive running
  input  wire logic [fcdf_pkg::CUR_W-1:0]    out_current,      // Current, 0.01 percent of rated
  input  wire logic [fcdf_pkg::FREQ_W-1:0]   fwd_freq_threshold, // Forward threshold, 0.01 Hz
  input  wire logic [fcdf_pkg::FREQ_W-1:0]   rev_freq_threshold, // Reverse threshold, 9999 = same
  input  wire logic [fcdf_pkg::PCT_W-1:0]    overcurrent_level,  // Percent, 0 to 200
  input  wire logic [fcdf_pkg::TIME_W-1:0]   overcurrent_delay,  // 10 ms units, 0 to 1000
  input  wire logic [fcdf_pkg::PCT_W-1:0]    zero_current_level, // Percent, 0 disables
  input  wire logic [fcdf_pkg::TIME_W-1:0]   zero_current_time,  // ms, 0 to 1000
  output logic                               freq_reached_flag,  // Registered
  output logic                               overcurrent_flag,   // Registered
  output logic                               zero_current_flag   // Registered
);
  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [fcdf_pkg::TICK_W-1:0] tcnt;
    logic [3:0]                  dcnt;
    logic                        ms;
    logic                        ten_ms;
    logic                        freq;
    logic                        oc_cond;
    logic                        zc_cond;
  } fcdf_st_t;
  fcdf_st_t s_q, s_d;

  logic [fcdf_pkg::FREQ_W-1:0] thr;
  logic [fcdf_pkg::PCT_W-1:0]  oc_lvl, zc_lvl;
  logic [fcdf_pkg::CUR_W-1:0]  oc_cur, zc_cur;
  logic [fcdf_pkg::TIME_W-1:0] oc_dly, zc_tim;
  logic oc_q, zc_q;

  // ---------------------------------------------------------------------------
  // Settings, clamped to their ranges so an out-of-range value cannot overflow
  // ---------------------------------------------------------------------------
  always_comb begin
    oc_lvl = (overcurrent_level > fcdf_pkg::PCT_MAX) ? fcdf_pkg::PCT_MAX : overcurrent_level;
    zc_lvl = (zero_current_level > fcdf_pkg::PCT_MAX) ? fcdf_pkg::PCT_MAX : zero_current_level;
    oc_dly = (overcurrent_delay > fcdf_pkg::OC_DELAY_MAX) ? fcdf_pkg::OC_DELAY_MAX
                                                          : overcurrent_delay;
    zc_tim = (zero_current_time > fcdf_pkg::ZC_TIME_MAX) ? fcdf_pkg::ZC_TIME_MAX
                                                         : zero_current_time;
    oc_cur = 16'(oc_lvl * fcdf_pkg::PCT_SCALE);
    zc_cur = 16'(zc_lvl * fcdf_pkg::PCT_SCALE);
    // Reverse threshold only replaces forward one when not the 9999 code
    if (reverse_run && rev_freq_threshold != fcdf_pkg::REV_SAME) thr = rev_freq_threshold;
    else thr = fwd_freq_threshold;
  end

  // ---------------------------------------------------------------------------
  // Comparisons and time base
  // ---------------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.ms = 1'b0;
    s_d.ten_ms = 1'b0;
    if (s_q.tcnt == fcdf_pkg::TICK_W'(TICK_CYC - 1)) begin
      s_d.tcnt = '0;
      s_d.ms = 1'b1;
      if (s_q.dcnt == fcdf_pkg::DEC_LAST) begin
        s_d.dcnt = '0;
        s_d.ten_ms = 1'b1;
      end else begin
        s_d.dcnt = s_q.dcnt + 1'b1;
      end
    end else begin
      s_d.tcnt = s_q.tcnt + 1'b1;
    end
    // Raw frequency is used so slip compensation never shifts the threshold
    s_d.freq = !dc_brake && (out_freq_raw >= thr);
    // Current only judged while running; auto-tuning does not gate it
    s_d.oc_cond = running && (out_current > oc_cur);
    s_d.zc_cond = running && (zc_lvl != '0) && (out_current < zc_cur);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) s_q <= '0;
    else s_q <= s_d;
  end

  // ---------------------------------------------------------------------------
  // Qualification timers; response well under 0.1 s beyond programmed time
  // ---------------------------------------------------------------------------
  fcdf_qual #(.TW(fcdf_pkg::TIME_W)) u_oc (
    .clk       (clk),
    .resetn    (resetn),
    .tick      (s_q.ten_ms),
    .hold_tick (s_q.ms),
    .cond      (s_q.oc_cond),
    .limit     (oc_dly),
    .hold      (fcdf_pkg::HOLD_MS),
    .flag      (oc_q)
  );
  fcdf_qual #(.TW(fcdf_pkg::TIME_W)) u_zc (
    .clk       (clk),
    .resetn    (resetn),
    .tick      (s_q.ms),
    .hold_tick (s_q.ms),
    .cond      (s_q.zc_cond),
    .limit     (zc_tim),
    .hold      (fcdf_pkg::HOLD_MS),
    .flag      (zc_q)
  );

  // Flags go out to the network master straight from flip-flops
  assign freq_reached_flag = s_q.freq;
  assign overcurrent_flag  = oc_q;
  assign zero_current_flag = zc_q;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  a_brake_clears_freq: assert property (@(posedge clk) disable iff (!resetn)
    dc_brake |=> !freq_reached_flag)
    else $error("frequency flag set during brake");
  a_freq_fwd_compare: assert property (@(posedge clk) disable iff (!resetn)
    (!dc_brake && !reverse_run) |=> freq_reached_flag == ($past(out_freq_raw) >= $past(fwd_freq_threshold)))
    else $error("forward compare wrong");
  a_rev_same_code: assert property (@(posedge clk) disable iff (!resetn)
    (!dc_brake && rev_freq_threshold == fcdf_pkg::REV_SAME) |=>
      freq_reached_flag == ($past(out_freq_raw) >= $past(fwd_freq_threshold)))
    else $error("9999 did not select forward threshold");
  a_rev_own_thr: assert property (@(posedge clk) disable iff (!resetn)
    (!dc_brake && reverse_run && rev_freq_threshold != fcdf_pkg::REV_SAME) |=>
      freq_reached_flag == ($past(out_freq_raw) >= $past(rev_freq_threshold)))
    else $error("reverse compare wrong");
  a_zc_disabled: assert property (@(posedge clk) disable iff (!resetn)
    (zero_current_level == '0) [*3] |=> !s_q.zc_cond)
    else $error("zero current detected while disabled");
  a_idle_no_oc: assert property (@(posedge clk) disable iff (!resetn)
    !running |=> !s_q.oc_cond)
    else $error("current judged while stopped");
  a_oc_rise_cause: assert property (@(posedge clk) disable iff (!resetn)
    $rose(overcurrent_flag) |-> $past(s_q.oc_cond))
    else $error("overcurrent flag without condition");
  a_zc_rise_cause: assert property (@(posedge clk) disable iff (!resetn)
    $rose(zero_current_flag) |-> $past(s_q.zc_cond))
    else $error("zero current flag without condition");
endmodule : fcdf_top
`default_nettype wire

// ### logic/fcdf_pkg.sv
// Constants shared by the frequency and current detect flag block
//
// Function
// - Frequency flag set when output frequency is at or above forward threshold.
// - Reverse threshold not 9999 applies only during reverse rotation.
// - Reverse threshold of 9999 means forward threshold used for reverse too.
// - Frequency flag forced off during DC injection braking.
// - Compared frequency is the value before slip compensation.
// - Overcurrent level 0 to 200 percent, default 150 percent.
// - Overcurrent delay 0 to 10 s, default 0 s.
// - Overcurrent flag after current stays above level longer than delay.
// - Overcurrent flag held at least about 100 ms.
// - Zero-current level 0 to 200 percent, default 5 percent.
// - Zero-current time 0 to 1 s, default 0.5 s.
// - Zero-current flag after current stays below level longer than time.
// - Zero-current flag held at least about 100 ms.
// - Zero-current level of 0 disables zero-current detection.
// - Current detection stays active during offline auto-tuning.
// - Current flags respond within roughly 0.1 s.
// - Current evaluated only while running; flags reported to network master.
`default_nettype none
package fcdf_pkg;
  // ---------------------------------------------------------------------------
  // Formats and timing
  // ---------------------------------------------------------------------------
  localparam int FREQ_W            = 16;        // Frequency in 0.01 Hz units
  localparam int PCT_W             = 8;         // Percent of rated current
  localparam int CUR_W             = 16;        // Current in 0.01 percent units
  localparam int TIME_W            = 11;        // Times in ms, overcurrent delay in 10 ms units
  localparam int TICK_W            = 18;        // Cycle counter for 1 ms tick
  localparam int CLK_MHZ           = 200;
  localparam int TICK_NS           = 1000000;   // One millisecond in ns
  localparam int TICK_CYC          = TICK_NS * CLK_MHZ / 1000;
  localparam logic [FREQ_W-1:0] REV_SAME = 16'h270f; // Setting 9999
  localparam logic [PCT_W-1:0]  PCT_MAX  = 8'hc8;    // 200 percent
  localparam logic [PCT_W-1:0]  OC_LEVEL_DEF = 8'h96; // 150 percent
  localparam logic [PCT_W-1:0]  ZC_LEVEL_DEF = 8'h05; // 5 percent
  localparam logic [TIME_W-1:0] OC_DELAY_MAX = 11'h3e8; // 10 s in 10 ms units
  localparam logic [TIME_W-1:0] OC_DELAY_DEF = 11'h000;
  localparam logic [TIME_W-1:0] ZC_TIME_MAX  = 11'h3e8; // 1 s in ms
  localparam logic [TIME_W-1:0] ZC_TIME_DEF  = 11'h1f4; // 0.5 s in ms
  localparam logic [TIME_W-1:0] HOLD_MS      = 11'h064; // 100 ms minimum hold
  localparam logic [CUR_W-1:0]  PCT_SCALE    = 16'h0064; // Percent to 0.01 percent
  localparam logic [3:0]        DEC_LAST     = 4'h9;     // Last ms of each 10 ms period
endpackage : fcdf_pkg
`default_nettype wire

// ### logic/fcdf_qual.sv
// Qualify a condition for a programmed time, then hold the flag a minimum time
`timescale 1ns/1ps
`default_nettype none
module fcdf_qual #(
  parameter int TW = 11
) (
  input  wire logic          clk,      // 200 MHz clock
  input  wire logic          resetn,   // Async reset, active low
  input  wire logic          tick,     // One pulse per time unit
  input  wire logic          hold_tick,// One pulse per millisecond
  input  wire logic          cond,     // Raw condition
  input  wire logic [TW-1:0] limit,    // Qualification time in tick units
  input  wire logic [TW-1:0] hold,     // Minimum hold in ms
  output logic               flag      // Qualified flag, registered
);
  typedef struct packed {
    logic [TW-1:0] cnt;
    logic [TW-1:0] hcnt;
    logic          flag;
  } fcdf_qst_t;
  fcdf_qst_t s_q, s_d;

  // Timer restarts on an early drop; flag held until the hold expires and the condition is no longer qualified
  always_comb begin
    s_d = s_q;
    if (!cond) begin
      s_d.cnt = '0;
    end else if (tick && s_q.cnt <= limit) begin
      s_d.cnt = s_q.cnt + 1'b1;
    end
    if (s_q.flag) begin
      if (hold_tick && s_q.hcnt != hold) s_d.hcnt = s_q.hcnt + 1'b1;
      if (s_q.hcnt == hold && !(cond && s_q.cnt > limit)) begin
        s_d.flag = 1'b0;
        s_d.hcnt = '0;
      end
    end else if (cond && s_q.cnt > limit) begin
      s_d.flag = 1'b1;
      s_d.hcnt = '0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) s_q <= '0;
    else s_q <= s_d;
  end
  assign flag = s_q.flag;

  a_flag_needs_cond: assert property (@(posedge clk) disable iff (!resetn)
    $rose(s_q.flag) |-> $past(cond) && $past(s_q.cnt) > $past(limit))
    else $error("flag rose without qualified condition");
  a_hold_min: assert property (@(posedge clk) disable iff (!resetn)
    $fell(s_q.flag) |-> $past(s_q.hcnt) == $past(hold))
    else $error("flag dropped before hold time");
  a_timer_restart: assert property (@(posedge clk) disable iff (!resetn)
    !cond |=> s_q.cnt == '0)
    else $error("timer not restarted");
endmodule : fcdf_qual
`default_nettype wire

// ### verification/fcdf_net_master.sv
// Field network master model that polls the three detect flags
`timescale 1ns/1ps
`default_nettype none
module fcdf_net_master (
  input  wire logic       clk,               // 200 MHz clock
  input  wire logic       resetn,            // Async reset, active low
  input  wire logic       freq_reached_flag, // Flag from the block
  input  wire logic       overcurrent_flag,  // Flag from the block
  input  wire logic       zero_current_flag, // Flag from the block
  output logic      [2:0] status_q           // Last polled status word
);
  // ---------------------------------------------------------------------------
  // Polling
  // ---------------------------------------------------------------------------
  // Polls every cycle, so the bench sees the flags one cycle late but never misses one
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      status_q <= 3'h0;
    end else begin
      status_q <= {zero_current_flag, overcurrent_flag, freq_reached_flag};
    end
  end
endmodule : fcdf_net_master
`default_nettype wire

// ### verification/tb_fcdf_top.sv
// Self-checking testbench for the frequency and current detect flag block
`timescale 1ns/1ps
`default_nettype none
module tb_fcdf_top;
  // ---------------------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------------------
  logic                          clk = 1'b0;
  logic                          resetn;
  logic [fcdf_pkg::FREQ_W-1:0]   out_freq_raw, fwd_freq_threshold, rev_freq_threshold;
  logic                          reverse_run, dc_brake, running;
  logic [fcdf_pkg::CUR_W-1:0]    out_current;
  logic [fcdf_pkg::PCT_W-1:0]    overcurrent_level, zero_current_level;
  logic [fcdf_pkg::TIME_W-1:0]   overcurrent_delay, zero_current_time;
  logic                          freq_reached_flag, overcurrent_flag, zero_current_flag;
  logic [2:0]                    status_q;
  int                            num_errors = 0;
  int                            compares = 0;
  localparam int TICK     = 8;                                  // Short ms tick so timers fit the run
  localparam int TEN_MS   = 10 * TICK;
  localparam int HOLD_CYC = int'(fcdf_pkg::HOLD_MS) * TICK;     // 100 ms minimum hold
  localparam int ZC_CYC   = int'(fcdf_pkg::ZC_TIME_DEF) * TICK; // 0.5 s default time

  always #2.5 clk = ~clk;

  fcdf_top #(.TICK_CYC(TICK)) fcdf_top_inst (.clk(clk), .resetn(resetn), .out_freq_raw(out_freq_raw),
    .reverse_run(reverse_run),
    .dc_brake(dc_brake), .running(running), .out_current(out_current), .fwd_freq_threshold(fwd_freq_threshold),
    .rev_freq_threshold(rev_freq_threshold), .overcurrent_level(overcurrent_level),
    .overcurrent_delay(overcurrent_delay), .zero_current_level(zero_current_level),
    .zero_current_time(zero_current_time), .freq_reached_flag(freq_reached_flag),
    .overcurrent_flag(overcurrent_flag), .zero_current_flag(zero_current_flag));
  fcdf_net_master fcdf_net_master_inst (.clk(clk), .resetn(resetn), .freq_reached_flag(freq_reached_flag),
    .overcurrent_flag(overcurrent_flag), .zero_current_flag(zero_current_flag), .status_q(status_q));

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic close_out();
    $display("Counts: %0d compares, %0d mismatches", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out

  // Applies one frequency setup and returns the flag once its one-cycle latency has passed
  task automatic freq_case(input logic [15:0] f, fw, rv, input logic rev, brk, output logic seen);
    @(posedge clk);
    #1;
    out_freq_raw = f;
    fwd_freq_threshold = fw;
    rev_freq_threshold = rv;
    reverse_run = rev;
    dc_brake = brk;
    repeat (2) @(posedge clk);
    #1;
    seen = freq_reached_flag;
  endtask : freq_case

  // Watches both current flags for a span; any non-zero sample counts as raised
  task automatic watch_quiet(input int cyc, output logic oc_bad, zc_bad);
    oc_bad = 1'b0;
    zc_bad = 1'b0;
    repeat (cyc) begin
      @(posedge clk);
      #1;
      if (overcurrent_flag !== 1'b0) oc_bad = 1'b1;
      if (zero_current_flag !== 1'b0) zc_bad = 1'b1;
    end
  endtask : watch_quiet

  // Counts cycles until the chosen current flag shows the wanted level; gives up after lim
  task automatic count_until(input logic zc, input logic lvl, input int lim, output int n);
    n = 0;
    while (n < lim && (zc ? zero_current_flag : overcurrent_flag) !== lvl) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask : count_until

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  // Boundary of the compare, both directions, the same-as-forward code and braking
  task automatic t_freq();
    logic s;
    freq_case(16'h0258, 16'h0258, fcdf_pkg::REV_SAME, 1'b0, 1'b0, s);
    check("freq at fwd", s, 16'h1);
    freq_case(16'h0257, 16'h0258, fcdf_pkg::REV_SAME, 1'b0, 1'b0, s);
    check("freq below fwd", s, 16'h0);
    freq_case(16'h0258, 16'h0258, fcdf_pkg::REV_SAME, 1'b1, 1'b0, s);
    check("rev same at fwd", s, 16'h1);
    freq_case(16'h0257, 16'h0258, fcdf_pkg::REV_SAME, 1'b1, 1'b0, s);
    check("rev same below", s, 16'h0);
    freq_case(16'h0c00, 16'h0800, 16'h1000, 1'b1, 1'b0, s);
    check("rev below rev thr", s, 16'h0);
    freq_case(16'h1000, 16'h0800, 16'h1000, 1'b1, 1'b0, s);
    check("rev at rev thr", s, 16'h1);
    freq_case(16'h0c00, 16'h0800, 16'h1000, 1'b0, 1'b0, s);
    check("fwd ignores rev thr", s, 16'h1);
    freq_case(16'hffff, 16'h0800, 16'h1000, 1'b0, 1'b1, s);
    check("brake forces off", s, 16'h0);
    freq_case(16'hffff, 16'h0800, 16'h1000, 1'b0, 1'b0, s);
    @(posedge clk);
    #1;
    check("master sees flag", {13'h0, status_q}, 16'h0001);
    $display("test freq done");
  endtask : t_freq

  // Gating: each span is long enough for an ungated flag to rise
  task automatic t_current();
    logic oc_bad, zc_bad;
    running = 1'b0;
    out_current = 16'hffff;
    watch_quiet(2000, oc_bad, zc_bad);
    check("oc while stopped", oc_bad, 16'h0);
    out_current = 16'h0000;
    zero_current_time = 11'h000;
    watch_quiet(2000, oc_bad, zc_bad);
    check("zc while stopped", zc_bad, 16'h0);
    running = 1'b1;
    zero_current_level = 8'h00;
    watch_quiet(2000, oc_bad, zc_bad);
    check("zc disabled", zc_bad, 16'h0);
    $display("test current done");
  endtask : t_current

  // Overcurrent: a short burst must not count on after a drop; then the flag and its hold
  task automatic t_oc();
    int n;
    overcurrent_delay = 11'h004;                       // 40 ms
    out_current = 16'h4000;                            // Above the 150 percent default
    count_until(1'b0, 1'b1, 300, n);
    check("oc during burst", 16'(n), 16'h012c);
    out_current = 16'h1388;
    repeat (3) @(posedge clk);
    #1;
    out_current = 16'h4000;
    count_until(1'b0, 1'b1, 6 * TEN_MS, n);
    check("oc restart not early", 16'(n >= 4 * TEN_MS - 5), 16'h0001);
    check("oc rise in time", 16'(n <= 5 * TEN_MS + 10), 16'h0001);
    out_current = 16'h1388;
    @(posedge clk);
    #1;
    check("master sees oc", {13'h0, status_q}, 16'h0003);
    count_until(1'b0, 1'b0, HOLD_CYC + 100, n);
    check("oc hold long enough", 16'(n >= HOLD_CYC - 10), 16'h0001);
    check("oc hold ends", 16'(n <= HOLD_CYC + 10), 16'h0001);
    $display("test oc done");
  endtask : t_oc

  // Zero current at the default level and time, then the hold once current returns
  task automatic t_zc();
    int n;
    zero_current_level = fcdf_pkg::ZC_LEVEL_DEF;
    zero_current_time = fcdf_pkg::ZC_TIME_DEF;
    out_current = 16'h0064;                            // 1 percent, under the 5 percent default
    count_until(1'b1, 1'b1, ZC_CYC + 100, n);
    check("zc not early", 16'(n >= ZC_CYC - 5), 16'h0001);
    check("zc rise in time", 16'(n <= ZC_CYC + TICK + 10), 16'h0001);
    out_current = 16'h1388;
    count_until(1'b1, 1'b0, HOLD_CYC + 100, n);
    check("zc hold long enough", 16'(n >= HOLD_CYC - 10), 16'h0001);
    check("zc hold ends", 16'(n <= HOLD_CYC + 10), 16'h0001);
    $display("test zc done");
  endtask : t_zc

  // ---------------------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------------------
  initial begin
    resetn = 1'b0;
    {out_freq_raw, fwd_freq_threshold, rev_freq_threshold} = {16'h0000, 16'h0258, fcdf_pkg::REV_SAME};
    {reverse_run, dc_brake, running} = 3'h1;
    out_current = 16'h1388; // Half rated: between both levels
    overcurrent_level = fcdf_pkg::OC_LEVEL_DEF;
    overcurrent_delay = fcdf_pkg::OC_DELAY_DEF;
    zero_current_level = fcdf_pkg::ZC_LEVEL_DEF;
    zero_current_time = fcdf_pkg::ZC_TIME_DEF;
    repeat (5) @(posedge clk);
    #1;
    resetn = 1'b1;
    t_freq();
    t_current();
    t_oc();
    t_zc();
    close_out();
  end

  // Whole run is about 12500 cycles; allow about twice that
  initial begin
    #130000;
    num_errors++;
    close_out();
  end
endmodule : tb_fcdf_top
`default_nettype wire
